// [include/gpi_pkg.sv]
// constants for the gpio port block with pin interrupt channels
// Overview of operation
// - reset puts every pin in general-purpose mode
// - reset disables output driver and input buffer
// - data and direction have set/clear paths
// - each pin selects gpio independently
// - ten ports of 16 pins, muxed signals
// - each port has own control registers
// - port F select 01 routes disk bus
// - pin interrupts edge or level, polarity selectable
// - interrupt detection independent of gpio setup
// - four channels, 32 pins, one request each
// - half ports of eight assigned to channels
// - channel assign, mask, request, clear state
// - pin state and latches readable, mask-independent
// - channel mask, edge and invert have set/clear addresses
package gpi_pkg;
	localparam int NPORT   = 10;
	localparam int PW      = 16;
	localparam int NCH     = 4;
	localparam int NHALF   = 20;
	localparam int HSEL_W  = 5;
	// per-port word offsets, port n at n*PORT_STRIDE
	localparam logic [11:0] PORT_STRIDE = 12'h040;
	localparam logic [5:0]  P_FER     = 6'h00;
	localparam logic [5:0]  P_DATA    = 6'h04;
	localparam logic [5:0]  P_DSET    = 6'h08;
	localparam logic [5:0]  P_DCLR    = 6'h0C;
	localparam logic [5:0]  P_DIR     = 6'h10;
	localparam logic [5:0]  P_DIRSET  = 6'h14;
	localparam logic [5:0]  P_DIRCLR  = 6'h18;
	localparam logic [5:0]  P_INEN    = 6'h1C;
	localparam logic [5:0]  P_MUX     = 6'h20;
	localparam logic [5:0]  P_PIN     = 6'h24;
	// channel block base and word offsets, channel c at c*CH_STRIDE
	localparam logic [11:0] CH_BASE   = 12'h400;
	localparam logic [11:0] CH_STRIDE = 12'h040;
	localparam logic [5:0]  C_MSKSET  = 6'h00;
	localparam logic [5:0]  C_MSKCLR  = 6'h04;
	localparam logic [5:0]  C_REQ     = 6'h08;
	localparam logic [5:0]  C_ASSIGN  = 6'h0C;
	localparam logic [5:0]  C_EDGSET  = 6'h10;
	localparam logic [5:0]  C_EDGCLR  = 6'h14;
	localparam logic [5:0]  C_INVSET  = 6'h18;
	localparam logic [5:0]  C_INVCLR  = 6'h1C;
	localparam logic [5:0]  C_PINST   = 6'h20;
	localparam logic [5:0]  C_LATCH   = 6'h24;
	// global interrupt status/mask
	localparam logic [11:0] IRQ_STAT  = 12'h800;
	localparam logic [11:0] IRQ_MASK  = 12'h804;
	localparam logic [15:0] FER_RST   = 16'h0000;
	localparam logic [15:0] MUX_RST   = 16'h0000;
	localparam logic [1:0]  PF_DISK   = 2'h1;
	localparam int          PORT_F    = 5;
	localparam int          PORT_G    = 6;
	localparam logic [31:0] ASSIGN_RST = 32'h0302_0100;
endpackage

// [include/gpi_ch_if.sv]
// channel control bundle between top and channel module
`timescale 1ns/1ps
interface gpi_ch_if;
	logic [31:0] pins;
	logic [31:0] wdata;
	logic [5:0]  woff;
	logic        wen;
	logic [31:0] mask;
	logic [31:0] edge_mode;
	logic [31:0] invert;
	logic [31:0] latch;
	logic [31:0] req;
	logic        irq;
	modport top (output pins, wdata, woff, wen,
		input mask, edge_mode, invert, latch, req, irq);
	modport ch (input pins, wdata, woff, wen,
		output mask, edge_mode, invert, latch, req, irq);
endinterface

// [hw/gpi_channel.sv]
// one pin interrupt channel: mask, sense, polarity, latch, request
`timescale 1ns/1ps
module gpi_channel (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// control bundle
	gpi_ch_if.ch      cif
);
	logic [31:0] mask_q, edge_q, inv_q, latch_q, prev_q, lvl;
	logic [31:0] rise;
	assign lvl  = cif.pins ^ inv_q;
	assign rise = lvl & ~prev_q;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mask_q <= 32'h0000_0000;
			edge_q <= 32'h0000_0000;
			inv_q  <= 32'h0000_0000;
		end else if (cif.wen) begin
			unique case (cif.woff)
				gpi_pkg::C_MSKSET: mask_q <= mask_q | cif.wdata;
				gpi_pkg::C_MSKCLR: mask_q <= mask_q & ~cif.wdata;
				gpi_pkg::C_EDGSET: edge_q <= edge_q | cif.wdata;
				gpi_pkg::C_EDGCLR: edge_q <= edge_q & ~cif.wdata;
				gpi_pkg::C_INVSET: inv_q  <= inv_q | cif.wdata;
				gpi_pkg::C_INVCLR: inv_q  <= inv_q & ~cif.wdata;
				default: ;
			endcase
		end
	end

	// latches ignore mask; new events win over clears
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			latch_q <= 32'h0000_0000;
			prev_q  <= 32'h0000_0000;
		end else begin
			prev_q <= lvl;
			for (int i = 0; i < 32; i++) begin
				if (!edge_q[i])
					latch_q[i] <= lvl[i];
				else if (rise[i])
					latch_q[i] <= 1'b1;
				else if (cif.wen && cif.woff == gpi_pkg::C_REQ && cif.wdata[i])
					latch_q[i] <= 1'b0;
			end
		end
	end

	assign cif.mask      = mask_q;
	assign cif.edge_mode = edge_q;
	assign cif.invert    = inv_q;
	assign cif.latch     = latch_q;
	assign cif.req       = latch_q & mask_q;
	assign cif.irq       = |(latch_q & mask_q);

	chk_edge_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(edge_q[0] && latch_q[0] && !(cif.wen && cif.woff == gpi_pkg::C_REQ))
		|=> latch_q[0]) else $error("edge latch dropped");
	chk_level_follow: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!edge_q[0] |=> (latch_q[0] == $past(lvl[0])))
		else $error("level latch not following pin");
	chk_edge_catch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(edge_q[0] && rise[0] && $stable(edge_q)) |=> latch_q[0])
		else $error("edge not latched");
endmodule

// [hw/gpi_top.sv]
// gpio ports with function mux and four pin interrupt channels, apb slave
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module gpi_top #(
	parameter int NPORT = gpi_pkg::NPORT,
	parameter int PW    = gpi_pkg::PW
) (
	// clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	// apb slave
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [11:0]           paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output logic      [31:0]           prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// pins
	input  wire logic [NPORT*PW-1:0]   pin_in,
	output logic      [NPORT*PW-1:0]   pin_out,
	output logic      [NPORT*PW-1:0]   pin_oe_out,
	// peripheral side: function 0/1 outputs, enables, received levels
	input  wire logic [NPORT*PW-1:0]   func_do_in,
	input  wire logic [NPORT*PW-1:0]   func_oe_in,
	output logic      [NPORT*PW-1:0]   func_di_out,
	// disk interface routing and memory bus sharing
	input  wire logic [PW-1:0]         disk_if_data_lines_in,
	input  wire logic [PW-1:0]         disk_if_data_oe_in,
	input  wire logic [2:0]            disk_if_address_lines_in,
	output logic      [PW-1:0]         disk_if_data_lines_out,
	output logic                       disk_on_ports_out,
	// interrupts
	output logic [gpi_pkg::NCH-1:0]    pin_irq_out,
	output logic                       irq_out
);
	localparam int NP = NPORT * PW;

	// address decode assumes this layout
	if (NPORT != 10 || PW != 16) begin : g_bad_layout
		$error("port layout fixed at ten ports of sixteen pins");
	end

	logic [PW-1:0] fer_q   [NPORT];
	logic [PW-1:0] data_q  [NPORT];
	logic [PW-1:0] dir_q   [NPORT];
	logic [PW-1:0] inen_q  [NPORT];
	logic [PW-1:0] mux_q   [NPORT];
	logic [NP-1:0] pin_q;
	logic [31:0]   assign_q [gpi_pkg::NCH];
	logic [3:0]    stat_q, imask_q;

	logic          wr, rd, hit_port, hit_ch;
	logic [3:0]    pidx;
	logic [1:0]    cidx;
	logic [5:0]    off;
	assign wr   = psel_in && penable_in && pwrite_in && pready_out;
	assign rd   = psel_in && penable_in && !pwrite_in && pready_out;
	assign pidx = paddr_in[9:6];
	assign cidx = paddr_in[7:6];
	assign off  = paddr_in[5:0];
	assign hit_port = (paddr_in[11:10] == 2'b00) && (pidx < 4'(NPORT));
	assign hit_ch   = (paddr_in[11:8] == gpi_pkg::CH_BASE[11:8]);

	// port control registers
	always_ff @(posedge mclk_in) begin
		for (int p = 0; p < NPORT; p++) begin
			if (!rst_n_in) begin
				fer_q[p]  <= gpi_pkg::FER_RST;
				data_q[p] <= '0;
				dir_q[p]  <= '0;
				inen_q[p] <= '0;
				mux_q[p]  <= gpi_pkg::MUX_RST;
			end else if (wr && hit_port && pidx == 4'(p)) begin
				unique case (off)
					gpi_pkg::P_FER:    fer_q[p]  <= pwdata_in[PW-1:0];
					gpi_pkg::P_DATA:   data_q[p] <= pwdata_in[PW-1:0];
					gpi_pkg::P_DSET:   data_q[p] <= data_q[p] | pwdata_in[PW-1:0];
					gpi_pkg::P_DCLR:   data_q[p] <= data_q[p] & ~pwdata_in[PW-1:0];
					gpi_pkg::P_DIR:    dir_q[p]  <= pwdata_in[PW-1:0];
					gpi_pkg::P_DIRSET: dir_q[p]  <= dir_q[p] | pwdata_in[PW-1:0];
					gpi_pkg::P_DIRCLR: dir_q[p]  <= dir_q[p] & ~pwdata_in[PW-1:0];
					gpi_pkg::P_INEN:   inen_q[p] <= pwdata_in[PW-1:0];
					gpi_pkg::P_MUX:    mux_q[p]  <= pwdata_in[PW-1:0];
					default: ;
				endcase
			end
		end
	end

	// pin multiplexing: fer=0 gpio, else peripheral function, or disk bus on ports F/G when port F mux[1:0] is 01
	logic          disk_sel;
	logic [NP-1:0] nxt_do, nxt_oe, nxt_di;
	assign disk_sel = (mux_q[gpi_pkg::PORT_F][1:0] == gpi_pkg::PF_DISK);
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < PW; b++) begin
				nxt_do[p*PW+b] = data_q[p][b];
				nxt_oe[p*PW+b] = dir_q[p][b];
				nxt_di[p*PW+b] = 1'b0;
				if (fer_q[p][b]) begin
					nxt_do[p*PW+b] = func_do_in[p*PW+b];
					nxt_oe[p*PW+b] = func_oe_in[p*PW+b];
					nxt_di[p*PW+b] = pin_in[p*PW+b];
					if (disk_sel && p == gpi_pkg::PORT_F) begin
						nxt_do[p*PW+b] = disk_if_data_lines_in[b];
						nxt_oe[p*PW+b] = disk_if_data_oe_in[b];
					end
					if (disk_sel && p == gpi_pkg::PORT_G && b < 3) begin
						nxt_do[p*PW+b] = disk_if_address_lines_in[b];
						nxt_oe[p*PW+b] = 1'b1;
					end
				end
			end
		end
	end

	logic [NP-1:0] inen_flat;
	always_comb begin
		for (int p = 0; p < NPORT; p++)
			inen_flat[p*PW +: PW] = inen_q[p];
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pin_out                <= '0;
			pin_oe_out             <= '0;
			func_di_out            <= '0;
			disk_if_data_lines_out <= '0;
			disk_on_ports_out      <= 1'b0;
			pin_q                  <= '0;
		end else begin
			pin_out                <= nxt_do;
			pin_oe_out             <= nxt_oe;
			func_di_out            <= nxt_di;
			disk_if_data_lines_out <= pin_in[gpi_pkg::PORT_F*PW +: PW];
			disk_on_ports_out      <= disk_sel;
			pin_q                  <= pin_in;
		end
	end

	// half-port routing to channels, byte k of assign picks half port
	gpi_ch_if cif [gpi_pkg::NCH] ();
	genvar gc, gb;
	generate
		for (gc = 0; gc < gpi_pkg::NCH; gc++) begin : g_ch
			for (gb = 0; gb < 4; gb++) begin : g_byte
				logic [4:0] hs;
				assign hs = assign_q[gc][gb*8 +: gpi_pkg::HSEL_W];
				assign cif[gc].pins[gb*8 +: 8] = (hs < 5'(gpi_pkg::NHALF)) ?
					pin_q[hs*8 +: 8] : 8'h00;
			end
			assign cif[gc].wdata  = pwdata_in;
			assign cif[gc].woff   = off;
			assign cif[gc].wen    = wr && hit_ch && cidx == 2'(gc);
			gpi_channel u_ch (
				.mclk_in  (mclk_in),
				.rst_n_in (rst_n_in),
				.cif      (cif[gc])
			);
		end
	endgenerate

	always_ff @(posedge mclk_in) begin
		for (int c = 0; c < gpi_pkg::NCH; c++) begin
			if (!rst_n_in)
				assign_q[c] <= gpi_pkg::ASSIGN_RST;
			else if (wr && hit_ch && cidx == 2'(c) && off == gpi_pkg::C_ASSIGN)
				assign_q[c] <= pwdata_in;
		end
	end

	logic [3:0] ch_irq;
	logic [31:0] ch_rd [gpi_pkg::NCH];
	generate
		for (gc = 0; gc < gpi_pkg::NCH; gc++) begin : g_rd
			assign ch_irq[gc] = cif[gc].irq;
			always_comb begin
				unique case (off)
					gpi_pkg::C_MSKSET, gpi_pkg::C_MSKCLR: ch_rd[gc] = cif[gc].mask;
					gpi_pkg::C_REQ:    ch_rd[gc] = cif[gc].req;
					gpi_pkg::C_ASSIGN: ch_rd[gc] = assign_q[gc];
					gpi_pkg::C_EDGSET, gpi_pkg::C_EDGCLR: ch_rd[gc] = cif[gc].edge_mode;
					gpi_pkg::C_INVSET, gpi_pkg::C_INVCLR: ch_rd[gc] = cif[gc].invert;
					gpi_pkg::C_PINST:  ch_rd[gc] = cif[gc].pins;
					gpi_pkg::C_LATCH:  ch_rd[gc] = cif[gc].latch;
					default:           ch_rd[gc] = 32'h0000_0000;
				endcase
			end
		end
	endgenerate

	// apb read mux and answer; no wait state, pready on access phase
	logic [31:0] rdat;
	logic        bad;
	always_comb begin
		rdat = 32'h0000_0000;
		bad  = 1'b0;
		if (paddr_in == gpi_pkg::IRQ_STAT)
			rdat = {28'h0000000, stat_q};
		else if (paddr_in == gpi_pkg::IRQ_MASK)
			rdat = {28'h0000000, imask_q};
		else if (hit_ch)
			rdat = ch_rd[cidx];
		else if (hit_port) begin
			unique case (off)
				gpi_pkg::P_FER:    rdat = {16'h0000, fer_q[pidx]};
				gpi_pkg::P_DATA, gpi_pkg::P_DSET, gpi_pkg::P_DCLR:
					rdat = {16'h0000, data_q[pidx]};
				gpi_pkg::P_DIR, gpi_pkg::P_DIRSET, gpi_pkg::P_DIRCLR:
					rdat = {16'h0000, dir_q[pidx]};
				gpi_pkg::P_INEN:   rdat = {16'h0000, inen_q[pidx]};
				gpi_pkg::P_MUX:    rdat = {16'h0000, mux_q[pidx]};
				gpi_pkg::P_PIN:    rdat = {16'h0000, pin_q[pidx*PW +: PW] & inen_q[pidx]};
				default:           bad  = 1'b1;
			endcase
		end else
			bad = 1'b1;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in && !penable_in;
			prdata_out  <= rdat;
			pslverr_out <= psel_in && !penable_in && bad;
		end
	end

	// sticky channel events, cleared by reading status; set wins
	logic [3:0] ch_irq_q;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			stat_q   <= 4'h0;
			imask_q  <= 4'h0;
			ch_irq_q <= 4'h0;
			pin_irq_out <= 4'h0;
			irq_out  <= 1'b0;
		end else begin
			ch_irq_q    <= ch_irq;
			pin_irq_out <= ch_irq;
			// clear only what the read returned, so no event is lost
			if (rd && paddr_in == gpi_pkg::IRQ_STAT)
				stat_q <= (stat_q & ~prdata_out[3:0]) | (ch_irq & ~ch_irq_q);
			else
				stat_q <= stat_q | (ch_irq & ~ch_irq_q);
			if (wr && paddr_in == gpi_pkg::IRQ_MASK)
				imask_q <= pwdata_in[3:0];
			irq_out <= |(stat_q & imask_q);
		end
	end

	chk_reset_gpio: assert property (@(posedge mclk_in)
		$rose(rst_n_in) |-> (fer_q[0] == 16'h0000 && pin_oe_out == '0))
		else $error("pins not in gpio after reset");
	chk_pin_follow: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		pin_irq_out == $past(ch_irq)) else $error("channel request lag wrong");
	chk_apb_ready: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(psel_in && !penable_in) |=> pready_out) else $error("no ready");
	chk_dset_keep: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(wr && hit_port && pidx == 4'h0 && off == gpi_pkg::P_DSET)
		|=> ((data_q[0] & $past(data_q[0])) == $past(data_q[0])))
		else $error("set path cleared bits");
	chk_disk_route: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(disk_sel && fer_q[gpi_pkg::PORT_F][0] && $stable(disk_sel))
		|=> pin_out[gpi_pkg::PORT_F*PW] == $past(disk_if_data_lines_in[0]))
		else $error("disk data not on port f");
endmodule

// [dv/gpi_pin_model.sv]
// board side of the pins: outside drivers and pull-downs
`timescale 1ns/1ps
module gpi_pin_model #(
	parameter int N = 160
) (
	// design side
	input  wire logic [N-1:0] pin_out_in,
	input  wire logic [N-1:0] pin_oe_in,
	// outside drivers
	input  wire logic [N-1:0] ext_val_in,
	input  wire logic [N-1:0] ext_en_in,
	// resolved level
	output logic      [N-1:0] lvl_out
);
	// a pin nobody drives is pulled low
	assign lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_val_in);
endmodule

// [dv/testbench.sv]
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module testbench;
	logic         mclk_in = 1'b0;
	logic         rst_n_in = 1'b0;
	logic         psel_in = 1'b0;
	logic         penable_in = 1'b0;
	logic         pwrite_in = 1'b0;
	logic [11:0]  paddr_in = 12'h000;
	logic [31:0]  pwdata_in = 32'h0;
	logic [31:0]  prdata_out;
	logic         pready_out;
	logic         pslverr_out;
	logic [159:0] pin_lvl;
	logic [159:0] pin_out;
	logic [159:0] pin_oe;
	logic [159:0] ext_val = '0;
	logic [159:0] ext_en = '0;
	logic [159:0] func_do = '0;
	logic [159:0] func_oe = '0;
	logic [159:0] func_di;
	logic [15:0]  disk_d = 16'h0000;
	logic [15:0]  disk_oe = 16'h0000;
	logic [2:0]   disk_a = 3'h0;
	logic [15:0]  disk_q;
	logic         disk_on;
	logic [3:0]   pin_irq;
	logic         irq;
	logic [31:0]  rd;
	logic         err;
	int           fail_count = 0;
	int           checked = 0;
	int           cycles = 0;

	always #12.5 mclk_in = ~mclk_in;

	gpi_top dut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .pin_in(pin_lvl), .pin_out(pin_out),
		.pin_oe_out(pin_oe), .func_do_in(func_do), .func_oe_in(func_oe),
		.func_di_out(func_di), .disk_if_data_lines_in(disk_d), .disk_if_data_oe_in(disk_oe),
		.disk_if_address_lines_in(disk_a), .disk_if_data_lines_out(disk_q),
		.disk_on_ports_out(disk_on), .pin_irq_out(pin_irq), .irq_out(irq)
	);

	gpi_pin_model board (
		.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .lvl_out(pin_lvl)
	);

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// setup, access until pready, release, one idle edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		@(posedge mclk_in);
		while (pready_out !== 1'b1) begin
			@(posedge mclk_in);
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_in);
	endtask

	task automatic t_reset();
		chk({31'h0, |pin_oe}, 32'h0);
		chk({28'h0, pin_irq}, 32'h0);
		rdc(12'h240, 32'h0);
		rdc(12'h01C, 32'h0);
		rdc(12'h44C, 32'h0302_0100);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask

	task automatic t_gpio();
		ext_en[55] <= 1'b1;
		ext_val[55] <= 1'b1;
		wr(12'h0C8, 32'h0000_00FF);
		wr(12'h0CC, 32'h0000_000F);
		rdc(12'h0C4, 32'h0000_00F0);
		wr(12'h0D4, 32'h0000_0030);
		wr(12'h0D8, 32'h0000_0010);
		rdc(12'h0D0, 32'h0000_0020);
		chk({16'h0, pin_oe[63:48]}, 32'h0000_0020);
		chk({31'h0, pin_out[53]}, 32'h1);
		wr(12'h0DC, 32'h0000_0060);
		wait_n(2);
		rdc(12'h0E4, 32'h0000_0020);
	endtask

	task automatic t_disk();
		disk_d <= 16'hA5C3;
		disk_oe <= 16'hFFFF;
		disk_a <= 3'h5;
		wr(12'h140, 32'h0000_FFFF);
		wr(12'h180, 32'h0000_0007);
		wr(12'h160, 32'h0000_0001);
		wait_n(3);
		chk({31'h0, disk_on}, 32'h1);
		chk({16'h0, pin_out[95:80]}, 32'h0000_A5C3);
		chk({16'h0, pin_oe[95:80]}, 32'h0000_FFFF);
		chk({16'h0, disk_q}, 32'h0000_A5C3);
		chk({29'h0, pin_out[98:96]}, 32'h0000_0005);
		chk({29'h0, pin_oe[98:96]}, 32'h0000_0007);
		chk({16'h0, func_di[95:80]}, 32'h0000_A5C3);
		func_do[95:80] <= 16'h1234;
		func_oe[95:80] <= 16'hFFFF;
		wr(12'h160, 32'h0000_0000);
		wait_n(2);
		chk({31'h0, disk_on}, 32'h0);
		chk({16'h0, pin_out[95:80]}, 32'h0000_1234);
	endtask

	task automatic t_edge();
		wr(12'h804, 32'h1);
		rdc(12'h804, 32'h1);
		wr(12'h410, 32'h1);
		wr(12'h400, 32'h1);
		ext_en[0] <= 1'b1;
		ext_val[0] <= 1'b1;
		wait_n(6);
		chk({28'h0, pin_irq}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdc(12'h424, 32'h1);
		rdc(12'h408, 32'h1);
		rdc(12'h800, 32'h1);
		rdc(12'h800, 32'h0);
		ext_val[0] <= 1'b0;
		wait_n(4);
		rdc(12'h424, 32'h1);
		wr(12'h408, 32'h1);
		wait_n(3);
		chk({28'h0, pin_irq}, 32'h0);
		wr(12'h404, 32'h1);
		ext_val[0] <= 1'b1;
		wait_n(4);
		rdc(12'h424, 32'h1);
		rdc(12'h420, 32'h1);
		chk({28'h0, pin_irq}, 32'h0);
		// falling edge counts once inverted
		wr(12'h418, 32'h1);
		wr(12'h408, 32'h1);
		ext_val[0] <= 1'b0;
		wait_n(4);
		rdc(12'h424, 32'h1);
		wr(12'h408, 32'h1);
	endtask

	task automatic t_level();
		wr(12'h418, 32'h2);
		wait_n(3);
		rdc(12'h424, 32'h2);
		ext_en[1] <= 1'b1;
		ext_val[1] <= 1'b1;
		wait_n(4);
		rdc(12'h424, 32'h0);
		wr(12'h44C, 32'h0302_0103);
		wr(12'h440, 32'h0000_00FF);
		ext_en[24] <= 1'b1;
		ext_val[24] <= 1'b1;
		wait_n(5);
		chk({28'h0, pin_irq}, 32'h2);
		rdc(12'h460, 32'h0100_0001);
		wr(12'h44C, 32'h0302_0114);
		wait_n(5);
		chk({28'h0, pin_irq}, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		t_reset();
		t_gpio();
		t_disk();
		t_edge();
		t_level();
		give_verdict();
	end
endmodule
